/* design/fpp_sequencer.sv */
`timescale 1ns/100ps
`include "fpp_cfg.svh"
// How it works
// - User flash readable only, never data-written
// - Latch map overrides external RAM select
// - Select field picks space shown to reads
// - Bits 6:0 byte, bits 14:7 page
// - Select decodes array, row, erase, reset, bytes
// - Launch only after key 5 then A
// - Key 5 idles; key A runs selection
// - Keys back to back or no program
// - Destination taken from final key write
// - Codes 4 and 5 write one byte; 6 and 7 do nothing
// - Security bits set only where erased
// - One to 128 latch bytes, any order
// - Page and bank from last load
// - Nothing loaded: program or latch reset does nothing, flags error
// - Latch writes ignored while busy
// - Page erased first; unloaded bytes stay FF
// - Busy flag tracks programming, read only
// - Loaded flag set on load, cleared on success
// - Error flag cleared by software or success
module fpp_sequencer (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] sec_byte_i,
  output fpp_pkg::fpp_cmd_s flash_cmd_o,
  output fpp_pkg::fpp_xd_s xdata_o,
  output logic [2:0] code_space_o,
  output logic flash_busy_o
);
  import fpp_pkg::*;

  localparam int ERC = `FPP_ERASE_CYC;
  localparam logic [7:0] ERASE_LOAD = 8'(`FPP_ERASE_CYC - 1);
  localparam logic [7:0] BYTE_LOAD = 8'(`FPP_BYTE_CYC - 1);

  fpp_state_s r;
  fpp_state_s n;
  logic wr_go;
  logic rd_go;
  logic ctrl_wr;
  logic [3:0] key;
  logic lat_try;

  ////////////////////////////////////////////////////////////////////////
  // Bus handshakes: ready rises one cycle after valid, and the request is taken while ready is high
  assign wr_go = r.awr && s_axi_awvalid && s_axi_wvalid;
  assign rd_go = r.arr && s_axi_arvalid;
  assign ctrl_wr = wr_go && s_axi_awaddr == `FPP_OFS_CTRL && s_axi_wstrb[0];
  assign key = s_axi_wdata[`FPP_KEY_MSB:`FPP_KEY_LSB];
  assign lat_try = wr_go && s_axi_awaddr == `FPP_OFS_XDATA
                   && s_axi_wstrb[0] && r.map;

  // Byte sent for one column; unloaded columns keep the erased value
  function automatic logic [7:0] prog_byte(fpp_state_s s, logic [6:0] c,
                                           logic [7:0] sec);
    logic [7:0] b;
    b = s.ldm[c] ? s.lat[c] : `FPP_ERASED_BYTE;
    if (s.op == `FPP_SEL_SEC && !s.erased) begin
      b = b & sec;
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic set_err;
    logic clr_err;
    logic [2:0] sel_w;
    set_err = 1'b0;
    clr_err = 1'b0;
    sel_w = s_axi_wdata[2:0];
    n = r;
    n.cmd.we = 1'b0;
    n.xd.we = 1'b0;
    // Write channel: both address and data are needed before ready
    n.awr = !r.awr && !r.bv && s_axi_awvalid && s_axi_wvalid;
    if (r.bv && s_axi_bready) begin
      n.bv = 1'b0;
    end
    if (wr_go) begin
      n.bv = 1'b1;
      n.bresp = `FPP_RESP_OK;
      case (s_axi_awaddr)
        `FPP_OFS_CTRL, `FPP_OFS_AUX, `FPP_OFS_BANK, `FPP_OFS_DATA_POINTER,
        `FPP_OFS_XDATA, `FPP_OFS_STAT: n.bresp = `FPP_RESP_OK;
        default: n.bresp = `FPP_RESP_ERR;
      endcase
      // Any access other than the key write breaks an armed sequence
      if (r.armed && !ctrl_wr) begin
        set_err = 1'b1;
        n.armed = 1'b0;
      end
    end
    if (rd_go && r.armed) begin
      set_err = 1'b1;
      n.armed = 1'b0;
    end
    if (wr_go && s_axi_wstrb[0]) begin
      case (s_axi_awaddr)
        `FPP_OFS_AUX: n.ext = s_axi_wdata[`FPP_EXT_BIT];
        `FPP_OFS_BANK: n.bank = s_axi_wdata[2:0];
        `FPP_OFS_STAT: clr_err = s_axi_wdata[`FPP_ERR_BIT];
        default: ;
      endcase
    end
    if (wr_go && s_axi_awaddr == `FPP_OFS_DATA_POINTER) begin
      if (s_axi_wstrb[0]) n.data_pointer[7:0] = s_axi_wdata[7:0];
      if (s_axi_wstrb[1]) n.data_pointer[15:8] = s_axi_wdata[15:8];
    end
    // Data-space write: latches when mapped, else plain RAM
    if (wr_go && s_axi_awaddr == `FPP_OFS_XDATA && s_axi_wstrb[0]) begin
      if (r.map) begin
        if (!r.busy) begin
          n.lat[r.data_pointer[6:0]] = s_axi_wdata[7:0];
          n.ldm[r.data_pointer[6:0]] = 1'b1;
          n.loaded = 1'b1;
          n.pg = r.data_pointer[14:7];
          n.pbank = r.data_pointer[15] ? r.bank : 3'h0;
        end
      end else begin
        n.xd.we = 1'b1;
        n.xd.ext = r.ext;
        n.xd.addr = r.data_pointer;
        n.xd.data = s_axi_wdata[7:0];
      end
    end
    // Keyed activation on the control register
    if (ctrl_wr) begin
      n.map = s_axi_wdata[`FPP_MAP_BIT];
      n.sel = sel_w;
      n.armed = 1'b0;
      if (key == `FPP_KEY_ARM) begin
        if (r.armed) set_err = 1'b1;
        n.armed = 1'b1;
      end else if (key == `FPP_KEY_GO) begin
        if (!r.armed || r.busy) begin
          set_err = 1'b1;
        end else begin
          case (sel_w)
            `FPP_SEL_ARRAY, `FPP_SEL_XROW, `FPP_SEL_SEC, `FPP_SEL_FUSE: begin
              if (!r.loaded) begin
                set_err = 1'b1;
              end else begin
                clr_err = 1'b1;
                n.loaded = 1'b0;
                n.op = sel_w;
                n.st = FPP_ERASE;
                n.cnt = ERASE_LOAD;
              end
            end
            `FPP_SEL_ERASE: begin
              clr_err = 1'b1;
              n.op = sel_w;
              n.st = FPP_ERASE;
              n.cnt = ERASE_LOAD;
            end
            `FPP_SEL_LRST: begin
              if (!r.loaded) begin
                set_err = 1'b1;
              end else begin
                clr_err = 1'b1;
                n.loaded = 1'b0;
                n.ldm = '0;
              end
            end
            default: ;
          endcase
        end
      end else if (r.armed) begin
        set_err = 1'b1;
      end
    end
    // Setting the error wins over any clear in the same cycle
    n.err = set_err || (r.err && !clr_err);
    // Program-memory reads see array, extra row or security byte
    case (n.sel)
      `FPP_SEL_XROW, `FPP_SEL_SEC: n.code_space = n.sel;
      default: n.code_space = `FPP_SEL_ARRAY;
    endcase
    // Erase then program sequencer
    case (r.st)
      FPP_IDLE: ;
      FPP_ERASE: begin
        n.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h00) begin
          if (r.op == `FPP_SEL_ERASE) begin
            n.erased = 1'b1;
            n.st = FPP_IDLE;
          end else begin
            n.st = FPP_PROG;
            n.cnt = BYTE_LOAD;
            n.col = 7'h00;
            n.cmd.we = 1'b1;
            n.cmd.col = 7'h00;
            n.cmd.data = prog_byte(r, 7'h00, sec_byte_i);
          end
        end
      end
      FPP_PROG: begin
        n.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h00) begin
          if (r.col == `FPP_LAST_COL || r.op == `FPP_SEL_SEC
              || r.op == `FPP_SEL_FUSE) begin
            n.st = FPP_IDLE;
          end else begin
            n.col = r.col + 7'h01;
            n.cnt = BYTE_LOAD;
            n.cmd.we = 1'b1;
            n.cmd.col = n.col;
            n.cmd.data = prog_byte(r, n.col, sec_byte_i);
          end
        end
      end
      default: n.st = FPP_IDLE;
    endcase
    n.cmd.erase = n.st == FPP_ERASE;
    n.cmd.space = n.op;
    n.cmd.page = r.pg;
    n.cmd.bank = r.pbank;
    n.busy = n.st != FPP_IDLE;
    // Read channel; the sampled status reflects this cycle's flops
    n.arr = !r.arr && !r.rv && s_axi_arvalid;
    if (r.rv && s_axi_rready) begin
      n.rv = 1'b0;
    end
    if (rd_go) begin
      n.rv = 1'b1;
      n.rresp = `FPP_RESP_OK;
      n.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `FPP_OFS_CTRL: n.rdata[3:0] = {r.map, r.sel};
        `FPP_OFS_STAT: n.rdata[2:0] = {r.err, r.loaded, r.busy};
        `FPP_OFS_AUX: n.rdata[`FPP_EXT_BIT] = r.ext;
        `FPP_OFS_BANK: n.rdata[2:0] = r.bank;
        `FPP_OFS_DATA_POINTER: n.rdata[15:0] = r.data_pointer;
        `FPP_OFS_XDATA: ;
        default: n.rresp = `FPP_RESP_ERR;
      endcase
    end
  end

  // State register; the all-zero value is the reset state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state flops
  assign s_axi_awready = r.awr;
  assign s_axi_wready = r.awr;
  assign s_axi_bvalid = r.bv;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arr;
  assign s_axi_rvalid = r.rv;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;
  assign flash_cmd_o = r.cmd;
  assign xdata_o = r.xd;
  assign code_space_o = r.code_space;
  assign flash_busy_o = r.busy;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_arm_no_op: assert property (
    ctrl_wr && key == `FPP_KEY_ARM && !r.busy |=> r.armed && !r.busy)
    else $error("arm key started an operation");
  a_go_launch: assert property (
    ctrl_wr && key == `FPP_KEY_GO && r.armed && !r.busy && r.loaded
    && s_axi_wdata[2:0] == `FPP_SEL_ARRAY |=> r.st == FPP_ERASE
    && r.op == `FPP_SEL_ARRAY && !r.err && !r.loaded)
    else $error("valid key pair did not launch");
  a_gap_breaks: assert property (
    r.armed && rd_go && !wr_go && !r.busy |=> !r.armed && r.err ##1 !r.busy)
    else $error("intervening access did not abort");
  a_empty_error: assert property (
    ctrl_wr && key == `FPP_KEY_GO && r.armed && !r.loaded
    && s_axi_wdata[2:0] == `FPP_SEL_FUSE |=> r.err && !r.busy)
    else $error("empty latches launched or no error");
  a_busy_hold: assert property (
    lat_try && r.busy |=> $stable(r.lat) && $stable(r.ldm))
    else $error("latch written while busy");
  a_load_flag: assert property (
    lat_try && !r.busy |=> r.loaded && r.ldm[$past(r.data_pointer[6:0])])
    else $error("loaded flag not set");
  a_err_clear: assert property (
    wr_go && s_axi_awaddr == `FPP_OFS_STAT && s_axi_wstrb[0]
    && s_axi_wdata[`FPP_ERR_BIT] && !r.armed |=> !r.err)
    else $error("error flag not cleared");
  a_unloaded_ff: assert property (
    r.cmd.we && r.cmd.space == `FPP_SEL_ARRAY && !r.ldm[r.cmd.col]
    |-> r.cmd.data == `FPP_ERASED_BYTE)
    else $error("unloaded byte not erased value");
  a_erase_len: assert property (
    $rose(r.st == FPP_ERASE) && r.op != `FPP_SEL_ERASE
    |-> ##ERC r.st == FPP_PROG && r.busy && r.cmd.we)
    else $error("erase phase length wrong");
  a_busy_flag: assert property (
    r.busy == (r.st != FPP_IDLE))
    else $error("busy flag disagrees with sequencer");
  a_map_steer: assert property (
    wr_go && s_axi_awaddr == `FPP_OFS_XDATA && r.map |=> !r.xd.we)
    else $error("mapped write reached data space");

  c_page_prog: cover property ($rose(r.st == FPP_PROG));
  c_full_erase: cover property (r.op == `FPP_SEL_ERASE && $fell(r.busy));
  c_seq_err: cover property ($rose(r.err));
  c_sec_write: cover property (r.cmd.we && r.cmd.space == `FPP_SEL_SEC);
endmodule

/* design/fpp_cfg.svh */
`ifndef FPP_CFG_SVH
`define FPP_CFG_SVH
// Register byte offsets
`define FPP_OFS_CTRL 5'h00
`define FPP_OFS_STAT 5'h04
`define FPP_OFS_AUX 5'h08
`define FPP_OFS_BANK 5'h0C
`define FPP_OFS_DATA_POINTER 5'h10
`define FPP_OFS_XDATA 5'h14
// Field positions
`define FPP_KEY_MSB 7
`define FPP_KEY_LSB 4
`define FPP_MAP_BIT 3
`define FPP_ERR_BIT 2
`define FPP_EXT_BIT 1
// Launch key values
`define FPP_KEY_ARM 4'h5
`define FPP_KEY_GO 4'hA
// Target space select codes
`define FPP_SEL_ARRAY 3'h0
`define FPP_SEL_XROW 3'h1
`define FPP_SEL_ERASE 3'h2
`define FPP_SEL_LRST 3'h3
`define FPP_SEL_SEC 3'h4
`define FPP_SEL_FUSE 3'h5
// Reset and fixed values
`define FPP_CTRL_RST 8'h00
`define FPP_ERASED_BYTE 8'hFF
`define FPP_LAST_COL 7'h7F
`define FPP_RESP_OK 2'h0
`define FPP_RESP_ERR 2'h2
// Timing, clock 25 MHz
`define FPP_CLK_NS 40
`define FPP_ERASE_NS 2000
`define FPP_BYTE_NS 160
`define FPP_ERASE_CYC ((`FPP_ERASE_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS)
`define FPP_BYTE_CYC ((`FPP_BYTE_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS)
`endif

/* design/fpp_pkg.sv */
package fpp_pkg;
  typedef enum logic [1:0] {FPP_IDLE, FPP_ERASE, FPP_PROG} fpp_st_e;
  // Command stream toward the flash array
  typedef struct packed {
    logic erase;
    logic we;
    logic [2:0] space;
    logic [2:0] bank;
    logic [7:0] page;
    logic [6:0] col;
    logic [7:0] data;
  } fpp_cmd_s;
  // Plain data-space write toward the RAM
  typedef struct packed {
    logic we;
    logic ext;
    logic [15:0] addr;
    logic [7:0] data;
  } fpp_xd_s;
  // Whole state of the sequencer
  typedef struct packed {
    fpp_st_e st;
    logic [7:0] cnt;
    logic [6:0] col;
    logic [2:0] op;
    logic busy;
    logic map;
    logic [2:0] sel;
    logic ext;
    logic [2:0] bank;
    logic [15:0] data_pointer;
    logic err;
    logic armed;
    logic loaded;
    logic erased;
    logic [127:0][7:0] lat;
    logic [127:0] ldm;
    logic [7:0] pg;
    logic [2:0] pbank;
    logic [2:0] code_space;
    logic awr;
    logic bv;
    logic [1:0] bresp;
    logic arr;
    logic rv;
    logic [1:0] rresp;
    logic [31:0] rdata;
    fpp_cmd_s cmd;
    fpp_xd_s xd;
  } fpp_state_s;
endpackage

/* verif/fpp_flash_model.sv */
`timescale 1ns/100ps
module fpp_flash_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire fpp_pkg::fpp_cmd_s cmd_i,
  output logic [7:0] sec_byte_o
);
  import fpp_pkg::*;
  // Security byte after power-up, arbitrary pattern
  parameter logic [7:0] SEC_INIT = 8'h0F;
  logic [7:0] img [0:127];
  logic [7:0] pg, last_d;
  logic [2:0] bk, sp;
  int wcnt, ecnt;
  ////////////////////////////////////////////////////////////////////////
  // Page image of the last program; erase wipes it so gaps show as FF
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sec_byte_o <= SEC_INIT;
      wcnt <= 0;
      ecnt <= 0;
    end else begin
      if (cmd_i.erase === 1'h1) begin
        ecnt <= ecnt + 1;
        for (int k = 0; k < 128; k++) img[k] <= 8'hFF;
      end
      if (cmd_i.we === 1'h1) begin
        wcnt <= wcnt + 1;
        img[cmd_i.col] <= cmd_i.data;
        pg <= cmd_i.page;
        bk <= cmd_i.bank;
        sp <= cmd_i.space;
        last_d <= cmd_i.data;
        if (cmd_i.space == 3'h4) sec_byte_o <= cmd_i.data;
      end
    end
  end
endmodule

/* verif/test_flash_page_program_sequencer.sv */
`timescale 1ns/100ps
`include "fpp_cfg.svh"
module test_flash_page_program_sequencer;
  import fpp_pkg::*;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, flash_busy_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rv;
  logic [7:0] sec_byte;
  logic [2:0] code_space;
  fpp_cmd_s flash_cmd;
  fpp_xd_s xdata, xd_last;
  int error_cnt = 0, cmp_count = 0, xd_n = 0, w0, e0;
  always #20 clk_i = ~clk_i;
  fpp_sequencer dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sec_byte_i(sec_byte),
    .flash_cmd_o(flash_cmd), .xdata_o(xdata), .code_space_o(code_space),
    .flash_busy_o(flash_busy_o));
  fpp_flash_model fm (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cmd_i(flash_cmd), .sec_byte_o(sec_byte));
  // Count every plain data-space write the block lets through, keep the last
  always @(posedge clk_i) begin
    if (xdata.we === 1'h1) begin
      xd_n <= xd_n + 1;
      xd_last <= xdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Outputs are looked at mid-cycle, so the edge that follows is the one
  // that samples them; read data is caught before the slave drops it
  task automatic hold(input int s);
    logic seen;
    seen = 1'h0;
    for (int i = 0; i < 4000 && seen !== 1'h1; i++) begin
      @(negedge clk_i);
      case (s)
        0: seen = s_axi_awready & s_axi_wready;
        1: begin
          seen = s_axi_bvalid;
          rr = s_axi_bresp;
        end
        2: seen = s_axi_arready;
        3: begin
          seen = s_axi_rvalid;
          rv = s_axi_rdata;
          rr = s_axi_rresp;
        end
        default: seen = ~flash_busy_o;
      endcase
    end
    if (seen !== 1'h1) begin
      error_cnt++;
      end_of_test();
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    hold(0);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    hold(1);
  endtask
  task automatic rd(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    hold(2);
    s_axi_arvalid <= 1'h0;
    hold(3);
  endtask
  task automatic st(input logic [31:0] e);
    rd(`FPP_OFS_STAT);
    chk(rv, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Lone launch key, clearing, and a launch with empty latches
  task automatic t_empty;
    st(32'h0000_0000);
    wr(`FPP_OFS_CTRL, 32'h0000_00A0);
    st(32'h0000_0004);
    wr(`FPP_OFS_STAT, 32'h0000_0004);
    st(32'h0000_0000);
    wr(`FPP_OFS_CTRL, 32'h0000_0058);
    wr(`FPP_OFS_CTRL, 32'h0000_00A8);
    st(32'h0000_0004);
    wr(`FPP_OFS_STAT, 32'h0000_0004);
  endtask
  // Two loads out of order; the second picks page and bank
  task automatic t_load;
    wr(`FPP_OFS_CTRL, 32'h0000_0008);
    wr(`FPP_OFS_DATA_POINTER, 32'h0000_0006);
    wr(`FPP_OFS_XDATA, 32'h0000_0011);
    wr(`FPP_OFS_BANK, 32'h0000_0003);
    wr(`FPP_OFS_DATA_POINTER, 32'h0000_8085);
    wr(`FPP_OFS_XDATA, 32'h0000_003C);
    st(32'h0000_0002);
  endtask
  // Broken sequence, then a reserved select
  task automatic t_break;
    wr(`FPP_OFS_CTRL, 32'h0000_0058);
    rd(5'h18);
    chk({30'h0, rr}, 32'h0000_0002);
    wr(`FPP_OFS_CTRL, 32'h0000_00A8);
    st(32'h0000_0006);
    wr(`FPP_OFS_STAT, 32'h0000_0004);
    chk({30'h0, rr}, 32'h0000_0000);
    wr(`FPP_OFS_CTRL, 32'h0000_0058);
    wr(5'h1C, 32'h0000_0000);
    chk({30'h0, rr}, 32'h0000_0002);
    wr(`FPP_OFS_CTRL, 32'h0000_00A8);
    st(32'h0000_0006);
    wr(`FPP_OFS_STAT, 32'h0000_0004);
    wr(`FPP_OFS_CTRL, 32'h0000_005E);
    wr(`FPP_OFS_CTRL, 32'h0000_00AE);
    st(32'h0000_0002);
  endtask
  // Page program with a latch write attempted while busy
  task automatic t_prog;
    w0 = fm.wcnt;
    e0 = fm.ecnt;
    wr(`FPP_OFS_CTRL, 32'h0000_0058);
    wr(`FPP_OFS_CTRL, 32'h0000_00A8);
    chk({31'h0, flash_busy_o}, 32'h0000_0001);
    wr(`FPP_OFS_XDATA, 32'h0000_0077);
    hold(4);
    chk(fm.wcnt - w0, 32'h0000_0080);
    chk(fm.ecnt - e0, 32'h0000_0032);
    chk({24'h0, fm.img[5]}, 32'h0000_003C);
    chk({24'h0, fm.img[6]}, 32'h0000_0011);
    chk({24'h0, fm.img[7]}, 32'h0000_00FF);
    chk({24'h0, fm.pg}, 32'h0000_0001);
    chk({29'h0, fm.bk}, 32'h0000_0003);
    st(32'h0000_0000);
  endtask
  // Data-space writes reach RAM only while the latches are unmapped
  task automatic t_xd;
    wr(`FPP_OFS_CTRL, 32'h0000_0000);
    wr(`FPP_OFS_AUX, 32'h0000_0002);
    wr(`FPP_OFS_DATA_POINTER, 32'h0000_1234);
    w0 = xd_n;
    wr(`FPP_OFS_XDATA, 32'h0000_005A);
    @(posedge clk_i);
    chk({6'h0, xd_last}, 32'h0312_345A);
    wr(`FPP_OFS_CTRL, 32'h0000_0008);
    wr(`FPP_OFS_XDATA, 32'h0000_0066);
    @(posedge clk_i);
    chk(xd_n - w0, 32'h0000_0001);
  endtask
  // Every select code against the space shown to code reads
  task automatic t_space;
    for (int s = 0; s < 8; s++) begin
      wr(`FPP_OFS_CTRL, s);
      chk({29'h0, code_space}, (s == 1 || s == 4) ? s : 0);
    end
  endtask
  // Security byte: select swapped at the last key, then full erase
  task automatic t_sec;
    wr(`FPP_OFS_CTRL, 32'h0000_0008);
    wr(`FPP_OFS_CTRL, 32'h0000_005B);
    wr(`FPP_OFS_CTRL, 32'h0000_00AB);
    st(32'h0000_0000);
    wr(`FPP_OFS_DATA_POINTER, 32'h0000_0000);
    wr(`FPP_OFS_XDATA, 32'h0000_00F3);
    w0 = fm.wcnt;
    wr(`FPP_OFS_CTRL, 32'h0000_0058);
    wr(`FPP_OFS_CTRL, 32'h0000_00AC);
    hold(4);
    chk(fm.wcnt - w0, 32'h0000_0001);
    chk({29'h0, fm.sp}, 32'h0000_0004);
    chk({24'h0, fm.last_d}, 32'h0000_0003);
    w0 = fm.wcnt;
    wr(`FPP_OFS_CTRL, 32'h0000_005A);
    wr(`FPP_OFS_CTRL, 32'h0000_00AA);
    chk({31'h0, flash_busy_o}, 32'h0000_0001);
    hold(4);
    chk(fm.wcnt - w0, 32'h0000_0000);
    wr(`FPP_OFS_XDATA, 32'h0000_00F3);
    wr(`FPP_OFS_CTRL, 32'h0000_005C);
    wr(`FPP_OFS_CTRL, 32'h0000_00AC);
    hold(4);
    chk({24'h0, fm.last_d}, 32'h0000_00F3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_i);
    t_empty();
    t_load();
    t_break();
    t_prog();
    t_xd();
    t_space();
    t_sec();
    end_of_test();
  end
endmodule
